// ==== rtl/pds_regs.sv ====
// Duplex selection, collision test and basic status register of a PHY.
// Assumes the serial management frame engine on ref_clk hands in
// one-cycle read and write strobes, that the live status comes from
// logic on ref_clk, and that the three pins are asynchronous.
`timescale 1ns/100ps

// Notes on behaviour
// R1: Hardware mode takes duplex from pin.
// R2: Hardware mode reports active link duplex.
// R3: Autoneg enabled takes negotiated duplex.
// R4: Autoneg off: control bit sets duplex.
// R5: Loopback ignores the duplex control bit.
// R6: Collision test off keeps col low.
// R7: Collision test works even in loopback.
// R8: Col follows tx enable within limits.
// R9: Reserved control bits read zero.
// R10: Manager writes reserved bits at defaults.
// R11: Sixteen-bit status register, reset to defaults.
// R12: Four-pair ability bit reads zero always.
// R13: Four ability bits reset to one.
// R14: Autoneg complete latches high, zero if off.
// R15: Remote fault latches high, resets zero.
// R16: Fixed ability ones; short frame bit zero.
// R17: Override bits writable only when enabled.
// R18: Reserved status bits zero, override writable.
// R19: Link latches low, jabber latches high.
// R20: Read releases latches to live state.
module pds_regs (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire pds_pkg::pds_mgmt_req_t mgmt_req,
  input  wire pds_pkg::pds_live_t     live,
  input  wire logic                   config_source_pin,
  input  wire logic                   duplex_select_pin,
  input  wire logic                   tx_en_pin,
  output logic [15:0]                 mgmt_rdata,
  output logic                        mgmt_rd_ack,
  output logic                        duplex_full,
  output logic                        duplex_status,
  output logic                        col
);

  generate
    if (pds_pkg::COL_OFF_CYC < pds_pkg::COL_PATH_CYC) begin : g_chk
      $error("Collision release path slower than allowed");
    end
  endgenerate

  // Bit 0 config source, bit 1 duplex select, bit 2 tx enable.
  logic [2:0]                      pin_s1_r;
  logic [2:0]                      pin_s2_r;
  logic [2:0]                      pin_s3_r;
  logic [2:0]                      pin_f_r;
  logic [2:0]                      pin_f_nxt;
  logic [2:0]                      pin_dis;
  logic                            sw_mode;
  logic                            dpx_pin;
  logic                            tx_en;
  logic                            ctl_dpx_r;
  logic                            coltest_r;
  logic                            duplex_nxt;
  logic                            duplex_r;
  logic                            dstat_r;
  logic                            col_r;
  logic [pds_pkg::STAT_CW_W-1:0]   cw_r;
  logic [2:0]                      lh_r;
  logic [2:0]                      lh_cond;
  logic [2:0]                      lh_nxt;
  logic                            ll_r;
  logic                            ll_nxt;
  logic                            wr_ctl;
  logic                            wr_stat;
  logic                            rd_stat;
  logic [15:0]                     ctl_val;
  logic [15:0]                     stat_val;
  logic [15:0]                     rdata_r;
  logic                            ack_r;

  // The first stage feeds only the second; the filter compares the
  // second and third so a metastable sample is never counted.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
      pin_f_r  <= 3'h0;
    end else begin
      pin_s1_r <= {tx_en_pin, duplex_select_pin, config_source_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r  <= pin_f_nxt;
    end
  end

  always_comb begin
    pin_dis   = pin_s2_r ^ pin_s3_r;
    pin_f_nxt = (pin_s2_r & ~pin_dis) | (pin_f_r & pin_dis);
  end

  assign sw_mode = pin_f_r[0];
  assign dpx_pin = pin_f_r[1];
  assign tx_en   = pin_f_r[2];

  assign wr_ctl  = mgmt_req.wr && (mgmt_req.addr == pds_pkg::CTRL_ADDR);
  assign wr_stat = mgmt_req.wr && (mgmt_req.addr == pds_pkg::STAT_ADDR);
  assign rd_stat = mgmt_req.rd && (mgmt_req.addr == pds_pkg::STAT_ADDR);

  // The duplex bit is stored in every mode so a later switch to software
  // mode picks up whatever the manager last wrote.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctl_dpx_r <= pds_pkg::CTRL_DPX_RST;
      coltest_r <= pds_pkg::CTRL_COLT_RST;
    end else if (wr_ctl) begin
      ctl_dpx_r <= mgmt_req.wdata[pds_pkg::CTRL_DPX_BIT];
      coltest_r <= mgmt_req.wdata[pds_pkg::CTRL_COLT_BIT];
    end
  end

  always_comb begin
    // R5: loopback ignores bit.
    if (live.loopback) begin
      duplex_nxt = 1'h1;
    // R1: pin sets duplex.
    end else if (!sw_mode) begin
      duplex_nxt = dpx_pin;
    // R3: negotiated duplex used.
    end else if (live.an_enable) begin
      duplex_nxt = live.an_full;
    // R4: control bit decides.
    end else begin
      duplex_nxt = ctl_dpx_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      duplex_r <= 1'h0;
      dstat_r  <= 1'h0;
    end else begin
      duplex_r <= duplex_nxt;
      // R2: active link duplex.
      dstat_r  <= duplex_nxt & live.link_ok;
    end
  end

  // Loopback does not gate col, so the test still works while looped.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      col_r <= 1'h0;
    end else begin
      // R6: gated by test bit.
      // R7: loopback not consulted.
      // R8: tracks tx enable.
      col_r <= coltest_r & tx_en;
    end
  end

  // R17: writes need override.
  // R18: reserved bits writable.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      // R13: ability bits reset.
      cw_r <= pds_pkg::STAT_CW_RST;
    end else if (wr_stat && live.ovr_en) begin
      cw_r <= mgmt_req.wdata[pds_pkg::STAT_CW_HI:pds_pkg::STAT_CW_LO];
    end
  end

  // The live condition is folded in even on the read cycle, so an event
  // that coincides with the clearing read is never lost.
  always_comb begin
    lh_cond = {live.an_enable & live.an_done, live.remote_fault,
               live.jabber};
    // R20: read releases latches.
    lh_nxt  = rd_stat ? lh_cond : (lh_r | lh_cond);
    ll_nxt  = rd_stat ? live.link_ok : (ll_r & live.link_ok);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lh_r <= 3'h0;
      ll_r <= 1'h0;
    end else begin
      // R15: remote fault latched.
      // R19: jabber and link latched.
      lh_r <= lh_nxt;
      ll_r <= ll_nxt;
    end
  end

  always_comb begin
    // R9: reserved bits zero.
    ctl_val = 16'h0000;
    ctl_val[pds_pkg::CTRL_DPX_BIT]  = ctl_dpx_r;
    ctl_val[pds_pkg::CTRL_COLT_BIT] = coltest_r;
    // R12: four-pair bit zero.
    // R16: fixed ability ones.
    stat_val = pds_pkg::STAT_RST & pds_pkg::STAT_RO_MASK;
    stat_val[pds_pkg::STAT_CW_HI:pds_pkg::STAT_CW_LO] = cw_r;
    // R14: zero when autoneg off.
    stat_val[pds_pkg::STAT_AN_DONE] = lh_r[2] & live.an_enable;
    stat_val[pds_pkg::STAT_RFAULT]  = lh_r[1];
    stat_val[pds_pkg::STAT_LINK]    = ll_r;
    stat_val[pds_pkg::STAT_JABBER]  = lh_r[0];
  end

  // R11: sixteen-bit read path.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
      ack_r   <= 1'h0;
    end else begin
      ack_r <= mgmt_req.rd;
      if (mgmt_req.rd) begin
        case (mgmt_req.addr)
          pds_pkg::CTRL_ADDR: rdata_r <= ctl_val;
          pds_pkg::STAT_ADDR: rdata_r <= stat_val;
          default:            rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign mgmt_rdata    = rdata_r;
  assign mgmt_rd_ack   = ack_r;
  assign duplex_full   = duplex_r;
  assign duplex_status = dstat_r;
  assign col           = col_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // R1: pin sets duplex.
  dpx_hw_mode_a: assert property ( // R1
    !sw_mode && !live.loopback |=> duplex_full == $past(dpx_pin))
    else $error("Hardware mode duplex not taken from pin");

  // R2: active link duplex.
  dpx_status_a: assert property ( // R2
    ##1 duplex_status == (duplex_full && $past(live.link_ok)))
    else $error("Duplex status does not follow active link");

  // R3: negotiated duplex used.
  dpx_autoneg_a: assert property ( // R3
    sw_mode && live.an_enable && !live.loopback
    |=> duplex_full == $past(live.an_full))
    else $error("Autoneg duplex not applied");

  // R4: control bit decides.
  dpx_manual_a: assert property ( // R4
    sw_mode && !live.an_enable && !live.loopback
    |=> duplex_full == $past(ctl_dpx_r))
    else $error("Manual duplex bit not applied");

  // R5: loopback ignores bit.
  dpx_loop_a: assert property ( // R5
    live.loopback |=> duplex_full)
    else $error("Duplex bit acted during loopback");

  // R6: gated by test bit.
  col_off_a: assert property ( // R6
    !coltest_r |=> !col)
    else $error("Col driven with collision test off");

  // R8: tracks tx enable.
  col_rise_a: assert property ( // R8
    coltest_r && $rose(tx_en) |-> ##[1:2] col)
    else $error("Col late after tx enable rose");

  // R8: release in time.
  col_fall_a: assert property ( // R8
    $fell(tx_en) |=> !col [*2])
    else $error("Col held after tx enable fell");

  // R9: reserved bits 6:0 zero.
  ctl_resv_a: assert property ( // R9
    mgmt_req.rd && mgmt_req.addr == pds_pkg::CTRL_ADDR
    |=> mgmt_rd_ack && mgmt_rdata[6:0] == 7'h00)
    else $error("Reserved control bits read nonzero");

  // R12: four-pair bit zero.
  stat_fixed_a: assert property ( // R12
    rd_stat |=> !mgmt_rdata[15] && mgmt_rdata[3] && mgmt_rdata[0])
    else $error("Fixed status bits wrong");

  // R17: writes need override.
  cw_block_a: assert property ( // R17
    wr_stat && !live.ovr_en |=> $stable(cw_r))
    else $error("Override bits changed without permission");

  // R17: writes accepted.
  cw_take_a: assert property ( // R17
    wr_stat && live.ovr_en
    |=> cw_r == $past(mgmt_req.wdata[14:6]))
    else $error("Permitted override write lost");

  // R15: remote fault latched.
  lh_hold_a: assert property ( // R15
    live.remote_fault ##1 !rd_stat |=> lh_r[1])
    else $error("Remote fault not held until read");

  // R19: link latched low.
  ll_hold_a: assert property ( // R19
    !live.link_ok |=> !ll_r)
    else $error("Link loss not latched");

  // R14: zero when autoneg off.
  an_off_a: assert property ( // R14
    rd_stat && !live.an_enable |=> !mgmt_rdata[5])
    else $error("Autoneg complete set while disabled");

  // R20: read releases latches.
  rd_release_a: assert property ( // R20
    rd_stat && !live.jabber |=> !lh_r[0])
    else $error("Jabber latch not released by read");

  col_test_c:   cover property (coltest_r && live.loopback && col);
  lh_read_c:    cover property (lh_r[2] && rd_stat);
  cw_write_c:   cover property (wr_stat && live.ovr_en);
  hw_mode_c:    cover property (!sw_mode && dpx_pin && duplex_full);

endmodule

// ==== rtl/pds_pkg.sv ====
// Constants and carrier types for the PHY duplex and status register block.
// Assumes a 200 MHz management-side clock and 5-bit register addresses.
package pds_pkg;

  // Register addresses on the management port.
  localparam logic [4:0]  CTRL_ADDR     = 5'h00;
  localparam logic [4:0]  STAT_ADDR     = 5'h01;

  // Control register fields and their values after reset.
  localparam int          CTRL_DPX_BIT  = 8;
  localparam int          CTRL_COLT_BIT = 7;
  localparam logic        CTRL_DPX_RST  = 1'h0;
  localparam logic        CTRL_COLT_RST = 1'h0;

  // Status register fields.
  localparam int          STAT_CW_HI    = 14;
  localparam int          STAT_CW_LO    = 6;
  localparam int          STAT_CW_W     = STAT_CW_HI - STAT_CW_LO + 1;
  localparam int          STAT_AN_DONE  = 5;
  localparam int          STAT_RFAULT   = 4;
  localparam int          STAT_LINK     = 2;
  localparam int          STAT_JABBER   = 1;
  localparam logic [15:0] STAT_RST      = 16'h7809;
  // Bits that never change: four-pair ability, autoneg ability, extended.
  localparam logic [15:0] STAT_RO_MASK  = 16'h8009;
  localparam logic [STAT_CW_W-1:0] STAT_CW_RST =
    STAT_RST[STAT_CW_HI:STAT_CW_LO];

  // Collision test timing, worst case taken at the 100 Mb/s bit time.
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          BIT_TIME_NS   = 10;
  localparam int          COL_ON_BITS   = 512;
  localparam int          COL_OFF_BITS  = 4;
  localparam int          COL_ON_CYC    =
    COL_ON_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int          COL_OFF_CYC   =
    COL_OFF_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
  // Pin to col: three synchroniser stages, filter, output flop.
  localparam int          COL_PATH_CYC  = 5;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pds_mgmt_req_t;

  typedef struct packed {
    logic loopback;
    logic an_enable;
    logic an_done;
    logic an_full;
    logic remote_fault;
    logic link_ok;
    logic jabber;
    logic ovr_en;
  } pds_live_t;

endpackage

// ==== tb/pds_sta_model.sv ====
// Station management model that issues one register access at a time.
// Assumes the register port takes one-cycle strobes on ref_clk.
`timescale 1ns/100ps
module pds_sta_model (
  input  wire logic            ref_clk,
  output pds_pkg::pds_mgmt_req_t req
);
  initial req = '0;

  task automatic access(input logic wr, input logic [4:0] addr,
                        input logic [15:0] data);
    @(posedge ref_clk);
    #1;
    req.wr = wr;
    req.rd = !wr;
    req.addr = addr;
    req.wdata = (addr == pds_pkg::CTRL_ADDR) ? (data & 16'h0180) :
                (addr == pds_pkg::STAT_ADDR) ? (data & 16'hF87F) : data;
    @(posedge ref_clk);
    #1;
    // Released qualifiers show garbage, not the last value.
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
  endtask
endmodule

// ==== tb/pds_regs_tb.sv ====
// Self-checking bench for the duplex and status register block.
// Assumes the management model in pds_sta_model drives the register port.
`timescale 1ns/100ps
module pds_regs_tb;
  logic                   ref_clk = 1'b0;
  logic                   rst_b = 1'b0;
  pds_pkg::pds_mgmt_req_t req;
  logic [7:0]             live = 8'h00;
  logic                   cfg_pin = 1'b1;
  logic                   dpx_pin = 1'b0;
  logic                   tx_en = 1'b0;
  logic [15:0]            rdata;
  logic                   ack, dfull, dstat, col;
  int                     n_mismatch = 0;
  int                     comparisons = 0;
  logic [31:0]            seed = 32'h48B1D234;
  logic [31:0]            r;
  logic [15:0]            w;

  always #2.5 ref_clk = ~ref_clk;

  pds_sta_model sta (.ref_clk(ref_clk), .req(req));
  pds_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .mgmt_req(req),
    .live(live), .config_source_pin(cfg_pin),
    .duplex_select_pin(dpx_pin), .tx_en_pin(tx_en), .mgmt_rdata(rdata),
    .mgmt_rd_ack(ack), .duplex_full(dfull), .duplex_status(dstat),
    .col(col));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic exp_dpx(input logic [7:0] lv, input logic sw,
                                   input logic pin, input logic b8);
    if (lv[7]) return 1'b1;
    if (!sw) return pin;
    if (lv[6]) return lv[4];
    return b8;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    sta.access(1'b0, a, 16'h0000);
    chk("rd_ack", 16'h0001, {15'h0000, ack});
    chk("rdata", e, rdata);
  endtask

  task automatic lh(input int lv, input int sb);
    @(posedge ref_clk);
    #1;
    live[lv] = 1'b1;
    @(posedge ref_clk);
    #1;
    live[lv] = 1'b0;
    rd(5'h01, 16'h7809 | (16'h0001 << sb));
    rd(5'h01, 16'h7809);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    rd(5'h01, 16'h7809);
    rd(5'h00, 16'h0000);
    $display("test reset values done");
    w = xs();
    sta.access(1'b1, 5'h01, w);
    rd(5'h01, 16'h7809);
    live[0] = 1'b1;
    sta.access(1'b1, 5'h01, w);
    rd(5'h01, {1'b0, w[14:11], 4'h0, w[6], 6'b001001});
    sta.access(1'b1, 5'h01, 16'h7800);
    live[0] = 1'b0;
    $display("test override writes done");
    live[6] = 1'b1;
    lh(1, 1);
    lh(3, 4);
    lh(5, 5);
    live = 8'h24;
    rd(5'h01, 16'h7809);
    rd(5'h01, 16'h780D);
    @(posedge ref_clk);
    #1;
    live[2] = 1'b0;
    @(posedge ref_clk);
    #1;
    live = 8'h04;
    rd(5'h01, 16'h7809);
    rd(5'h01, 16'h780D);
    $display("test latched status done");
    for (int i = 0; i < 24; i++) begin
      r = xs();
      cfg_pin = r[0];
      dpx_pin = r[1];
      live = {r[2] & r[3], r[4], 1'b0, r[5], 1'b0, r[6], 2'b00};
      tx_en = r[8];
      sta.access(1'b1, 5'h00, {7'h00, r[7], 8'h00});
      repeat (12) @(posedge ref_clk);
      #1;
      chk("duplex_full", {15'h0, exp_dpx(live, r[0], r[1], r[7])},
          {15'h0, dfull});
      chk("duplex_status", {15'h0, exp_dpx(live, r[0], r[1], r[7]) & r[6]},
          {15'h0, dstat});
      chk("col", 16'h0000, {15'h0, col});
    end
    $display("test duplex select done");
    tx_en = 1'b0;
    live[7] = 1'b1;
    sta.access(1'b1, 5'h00, 16'hFF80);
    rd(5'h00, 16'h0180);
    repeat (10) @(posedge ref_clk);
    #1;
    tx_en = 1'b1;
    for (int i = 0; i < pds_pkg::COL_ON_CYC && !col; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("col_on", 16'h0001, {15'h0, col});
    tx_en = 1'b0;
    for (int i = 0; i < pds_pkg::COL_OFF_CYC && col; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("col_off", 16'h0000, {15'h0, col});
    repeat (4) @(posedge ref_clk);
    #1;
    chk("col_cycle", 16'h0000, {15'h0, col});
    $display("test collision done");
    live = 8'h01;
    sta.access(1'b1, 5'h01, 16'h0000);
    rd(5'h01, 16'h0009);
    @(posedge ref_clk);
    #1;
    rst_b = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    chk("col_rst", 16'h0000, {15'h0, col});
    rd(5'h01, 16'h7809);
    rd(5'h00, 16'h0000);
    rd(5'h1F, 16'h0000);
    $display("test mid-run reset done");
    summarize();
  end
endmodule
